// *** core/mmcc_baseline.sv ***
// Per-function baseline store for zero mode.
// Assumes the function index is stable while a reading is handled.
`include "mmcc_params.svh"
`default_nettype none
module mmcc_baseline (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst,
  // Write side
  input  wire logic               wr_en,
  input  wire logic [2:0]         wr_func,
  input  wire logic signed [23:0] wr_value,
  // Read side
  input  wire logic [2:0]         rd_func,
  output logic signed [23:0]      rd_value
);
  import mmcc_pkg::*;

  logic signed [23:0] base_r [`MMCC_NUM_FUNC];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < `MMCC_NUM_FUNC; i++) begin
        base_r[i] <= 24'sh000000;
      end
    end else if (wr_en && (wr_func < 3'(`MMCC_NUM_FUNC))) begin
      base_r[wr_func] <= wr_value;
    end
  end

  // An index outside the table reads as a zero baseline.
  always_comb begin
    rd_value = 24'sh000000;
    if (rd_func < 3'(`MMCC_NUM_FUNC)) begin
      rd_value = base_r[rd_func];
    end
  end

endmodule : mmcc_baseline
`default_nettype wire

// *** core/mmcc_params.svh ***
// Constants of the measurement-control command block: register offsets,
// reset codes, command limits and timing figures.
// Assumes a 25 MHz core clock; included by bare name where needed.
`ifndef MMCC_PARAMS_SVH
`define MMCC_PARAMS_SVH

`define MMCC_CLK_MHZ        25
// Register offsets (byte addresses on the plain register port).
`define MMCC_REG_CTRL       8'h00
`define MMCC_REG_SETTINGS   8'h04
`define MMCC_REG_BASELINE   8'h08
// Field positions.
`define MMCC_CTRL_LINE50    0
`define MMCC_SET_RATE_LSB   0
`define MMCC_SET_ZERO       4
`define MMCC_SET_FILT_LSB   5
`define MMCC_SET_TRIG_LSB   8
`define MMCC_SET_RUN        11
`define MMCC_SET_OVF        12
// Reset and clear values.
`define MMCC_RATE_DEF       4'h2
`define MMCC_ZERO_DEF       1'b0
`define MMCC_TRIG_DEF       3'h6
`define MMCC_FILT_DEF_SMALL 2'h3
`define MMCC_FILT_DEF_NORM  2'h2
// Highest legal argument of each command.
`define MMCC_RATE_MAX       8'h09
`define MMCC_ZERO_MAX       8'h01
`define MMCC_FILT_MAX       8'h03
`define MMCC_TRIG_MAX       8'h07
// Bus readings always carry five and a half digits (eleven half digits).
`define MMCC_BUS_HALF_DIGITS 4'hB
// Integration periods in microseconds.
`define MMCC_PER_FAST_US    3330
`define MMCC_PER_LINE60_US  16660
`define MMCC_PER_LINE50_US  20000
`define MMCC_PER_SLOW_US    100000
// Decimal point dark time after a reading, in microseconds.
`define MMCC_DP_FLASH_US    50000
// Cycles after a completed reading in which an external edge aborts it.
`define MMCC_ABORT_WIN      3'h4
// Number of measuring functions with their own baseline.
`define MMCC_NUM_FUNC       5

`endif

// *** core/mmcc_pkg.sv ***
// Types shared by the measurement-control command block.
// Assumes mmcc_params.svh is on the include path.
`default_nettype none
package mmcc_pkg;

  typedef enum logic [2:0] {
    MMCC_OP_RATE    = 3'h0,
    MMCC_OP_ZERO    = 3'h1,
    MMCC_OP_FILTER  = 3'h2,
    MMCC_OP_TRIGGER = 3'h3,
    MMCC_OP_EXECUTE = 3'h4
  } mmcc_op_type;

  typedef struct packed {
    mmcc_op_type op;
    logic [7:0]  arg;
  } mmcc_cmd_type;

  typedef struct packed {
    logic [3:0] rate;
    logic       zero;
    logic [1:0] filter;
    logic [2:0] trig;
  } mmcc_set_type;

  typedef enum logic [2:0] {
    MMCC_ST_IDLE  = 3'b001,
    MMCC_ST_CONV  = 3'b010,
    MMCC_ST_DELIV = 3'b100
  } mmcc_state_type;

endpackage : mmcc_pkg
`default_nettype wire

// *** core/mmcc_top.sv ***
// Measurement-control command interpreter: rate, zero, filter, trigger.
// Assumes decoded bus commands and bus events arrive as core_clk pulses;
// the external trigger pin is asynchronous and is synchronised here.
//
// What this block does
// - Rate code 2 is the default: one line cycle, two samples.
// - Rate code 2 is loaded at reset and on device clear.
// - Rate codes map to 3.33 ms, line cycle or 100 ms and samples.
// - Codes 1 to 5 use 16.66 ms at 60 Hz, 20 ms at 50 Hz.
// - Bus readings are always formatted to five and a half digits.
// - With zero on, readings equal actual level minus stored baseline.
// - Zero argument 0 disables zero mode, argument 1 enables it.
// - Zero is disabled at reset and on device clear.
// - After zero enable the next conversion stores the baseline.
// - Every new zero enable re-arms baseline capture.
// - Each measuring function keeps its own baseline.
// - Range below stored baseline flags overflow and status.
// - The zero lamp is lit while zero mode is enabled.
// - Filter argument 0,1,2,3 averages 1, 64, 32, 8 samples.
// - Filter argument 0 comes only from the bus, not the panel.
// - Reset and device clear choose a filter fitting the range.
// - Continuous mode runs after one trigger until a clear or executed trigger command; one-shot needs each.
// - Trigger modes pair by source; even continuous, odd one-shot.
// - Trigger mode 6 is selected at reset and on device clear.
// - Lockout in modes 6 and 7 blocks panel triggers, not external.
// - In mode 7 an external edge after completion withholds bus delivery.
// - Decimal point steady while waiting, dark briefly per reading.
// - Received settings stay pending until the execute character.
`include "mmcc_params.svh"
`default_nettype none
module mmcc_top #(
  parameter int unsigned PER_FAST_CYC   = `MMCC_PER_FAST_US * `MMCC_CLK_MHZ,
  parameter int unsigned PER_LINE60_CYC = `MMCC_PER_LINE60_US * `MMCC_CLK_MHZ,
  parameter int unsigned PER_LINE50_CYC = `MMCC_PER_LINE50_US * `MMCC_CLK_MHZ,
  parameter int unsigned PER_SLOW_CYC   = `MMCC_PER_SLOW_US * `MMCC_CLK_MHZ,
  parameter int unsigned DP_FLASH_CYC   = `MMCC_DP_FLASH_US * `MMCC_CLK_MHZ
) (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst,
  // Register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [31:0]             reg_rdata,
  // Decoded bus commands and bus events
  input  wire logic               cmd_valid,
  input  wire mmcc_pkg::mmcc_cmd_type cmd,
  input  wire logic               dev_clear,
  input  wire logic               talk_addr,
  input  wire logic               group_trig,
  input  wire logic               local_lockout,
  // Front panel
  input  wire logic               panel_trig,
  input  wire logic               panel_filter_valid,
  input  wire logic [1:0]         panel_filter,
  output logic                    zero_lamp,
  output logic                    decimal_point,
  output logic                    overflow_message,
  // Rear panel
  input  wire logic               external_trigger_input,
  output logic                    conversion_done_output,
  // Converter
  input  wire logic [2:0]         func_sel,
  input  wire logic [23:0]        range_full,
  input  wire logic               range_small,
  output logic                    conv_start,
  input  wire logic               conv_done,
  input  wire logic signed [23:0] conv_value,
  output logic [23:0]             integ_cycles,
  output logic [3:0]              samples_log2,
  output logic [2:0]              filter_log2,
  // Readings
  output logic signed [23:0]      disp_value,
  output logic                    disp_valid,
  output logic signed [23:0]      bus_value,
  output logic                    bus_valid,
  output logic [3:0]              bus_half_digits,
  output logic                    status_overflow
);
  import mmcc_pkg::*;

  // Samples averaged per rate code, as a power of two.
  function automatic logic [3:0] rate_samples(input logic [3:0] code);
    logic [3:0] s;
    s = 4'h0;
    if (code >= 4'h1 && code <= 4'h5) begin
      s = code - 4'h1;
    end else if (code >= 4'h6) begin
      s = code - 4'h6;
    end
    return s;
  endfunction : rate_samples

  // Filter argument to averaged samples, as a power of two.
  function automatic logic [2:0] filt_samples(input logic [1:0] code);
    logic [2:0] s;
    case (code)
      2'h1:    s = 3'h6;
      2'h2:    s = 3'h5;
      2'h3:    s = 3'h3;
      default: s = 3'h0;
    endcase
    return s;
  endfunction : filt_samples

  mmcc_set_type   set_r;
  mmcc_set_type   pend_r;
  logic [3:0]     pend_flag_r;
  logic           arm_r;
  logic           line50_r;
  logic           run_r;
  mmcc_state_type state_r;
  logic [2:0]     win_r;
  logic [23:0]    dp_cnt_r;
  logic           ext_s1_r;
  logic           ext_s2_r;
  logic           ext_d_r;
  logic           ovf_d_r;
  logic signed [23:0] result_r;
  logic signed [23:0] base_val;
  logic           exec_evt;
  logic           ext_rise;
  logic           trig_evt;
  logic           clear;
  logic           capture;
  logic           start_ok;
  logic           abort_evt;
  logic [23:0]    base_mag;
  logic [1:0]     filt_def;

  assign clear    = rst | dev_clear;
  assign exec_evt = cmd_valid && (cmd.op == MMCC_OP_EXECUTE);
  assign ext_rise = ext_s2_r & ~ext_d_r;
  assign filt_def = range_small ? `MMCC_FILT_DEF_SMALL : `MMCC_FILT_DEF_NORM;

  // The pin passes two flops before the edge detector looks at it.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_d_r  <= 1'b0;
    end else begin
      ext_s1_r <= external_trigger_input;
      ext_s2_r <= ext_s1_r;
      ext_d_r  <= ext_s2_r;
    end
  end

  // Commands are collected here and only take effect on execute.
  always_ff @(posedge core_clk) begin
    if (clear || exec_evt) begin
      pend_flag_r <= 4'h0;
    end else if (cmd_valid) begin
      case (cmd.op)
        MMCC_OP_RATE: begin
          if (cmd.arg <= `MMCC_RATE_MAX) begin
            pend_r.rate    <= cmd.arg[3:0];
            pend_flag_r[0] <= 1'b1;
          end
        end
        MMCC_OP_ZERO: begin
          if (cmd.arg <= `MMCC_ZERO_MAX) begin
            pend_r.zero    <= cmd.arg[0];
            pend_flag_r[1] <= 1'b1;
          end
        end
        MMCC_OP_FILTER: begin
          if (cmd.arg <= `MMCC_FILT_MAX) begin
            pend_r.filter  <= cmd.arg[1:0];
            pend_flag_r[2] <= 1'b1;
          end
        end
        MMCC_OP_TRIGGER: begin
          if (cmd.arg <= `MMCC_TRIG_MAX) begin
            pend_r.trig    <= cmd.arg[2:0];
            pend_flag_r[3] <= 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Active settings; reset and device clear restore the defaults.
  always_ff @(posedge core_clk) begin
    if (clear) begin
      set_r.rate   <= `MMCC_RATE_DEF;
      set_r.zero   <= `MMCC_ZERO_DEF;
      set_r.filter <= filt_def;
      set_r.trig   <= `MMCC_TRIG_DEF;
    end else if (exec_evt) begin
      if (pend_flag_r[0]) set_r.rate   <= pend_r.rate;
      if (pend_flag_r[1]) set_r.zero   <= pend_r.zero;
      if (pend_flag_r[2]) set_r.filter <= pend_r.filter;
      if (pend_flag_r[3]) set_r.trig   <= pend_r.trig;
    end else if (panel_filter_valid && panel_filter != 2'h0) begin
      set_r.filter <= panel_filter;
    end
  end

  // Baseline capture is armed by each executed zero enable.
  always_ff @(posedge core_clk) begin
    if (clear) begin
      arm_r <= 1'b0;
    end else if (exec_evt && pend_flag_r[1]) begin
      arm_r <= pend_r.zero;
    end else if (capture) begin
      arm_r <= 1'b0;
    end
  end

  // Line frequency is set by software through the control register.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      line50_r <= 1'b0;
    end else if (reg_wr && reg_addr == `MMCC_REG_CTRL) begin
      line50_r <= reg_wdata[`MMCC_CTRL_LINE50];
    end
  end

  // Trigger source follows the upper two bits of the trigger mode.
  always_comb begin
    case (set_r.trig[2:1])
      2'h0:    trig_evt = talk_addr;
      2'h1:    trig_evt = group_trig;
      2'h2:    trig_evt = exec_evt;
      default: trig_evt = ext_rise | (panel_trig & ~local_lockout);
    endcase
  end

  // Continuous modes keep running once triggered; a clear or any executed trigger command stops them.
  always_ff @(posedge core_clk) begin
    if (clear || (exec_evt && pend_flag_r[3])) begin
      run_r <= 1'b0;
    end else if (trig_evt && !set_r.trig[0]) begin
      run_r <= 1'b1;
    end
  end

  assign start_ok = set_r.trig[0] ? trig_evt : (run_r | trig_evt);
  assign capture  = (state_r == MMCC_ST_CONV) && conv_done && arm_r
                    && set_r.zero;
  assign abort_evt = (set_r.trig == 3'h7) && ext_rise;

  // Conversion sequencing: a finished reading waits a short window
  // before going to the bus, so a looped-back done pulse can abort it.
  always_ff @(posedge core_clk) begin
    if (clear) begin
      state_r <= MMCC_ST_IDLE;
      win_r   <= 3'h0;
    end else begin
      case (state_r)
        MMCC_ST_IDLE: begin
          if (start_ok) begin
            state_r <= MMCC_ST_CONV;
          end
        end
        MMCC_ST_CONV: begin
          if (conv_done) begin
            state_r <= MMCC_ST_DELIV;
            win_r   <= `MMCC_ABORT_WIN;
          end
        end
        MMCC_ST_DELIV: begin
          if (abort_evt || win_r == 3'h1) begin
            state_r <= MMCC_ST_IDLE;
          end
          win_r <= win_r - 3'h1;
        end
        default: begin
          state_r <= MMCC_ST_IDLE;
        end
      endcase
    end
  end

  assign conv_start = (state_r == MMCC_ST_IDLE) && start_ok && !clear;

  mmcc_baseline u_baseline (
    .core_clk (core_clk),
    .rst      (rst),
    .wr_en    (capture),
    .wr_func  (func_sel),
    .wr_value (conv_value),
    .rd_func  (func_sel),
    .rd_value (base_val)
  );

  // Reading path: zeroed value to the display at once, to the bus after
  // the abort window has passed.
  always_ff @(posedge core_clk) begin
    if (clear) begin
      result_r   <= 24'sh000000;
      disp_value <= 24'sh000000;
      disp_valid <= 1'b0;
      bus_value  <= 24'sh000000;
      bus_valid  <= 1'b0;
      conversion_done_output <= 1'b0;
    end else begin
      disp_valid <= 1'b0;
      bus_valid  <= 1'b0;
      conversion_done_output <= 1'b0;
      if (state_r == MMCC_ST_CONV && conv_done) begin
        if (capture) begin
          result_r <= 24'sh000000;
        end else if (set_r.zero) begin
          result_r <= conv_value - base_val;
        end else begin
          result_r <= conv_value;
        end
        conversion_done_output <= 1'b1;
      end
      if (state_r == MMCC_ST_DELIV && win_r == `MMCC_ABORT_WIN) begin
        disp_value <= result_r;
        disp_valid <= 1'b1;
      end
      if (state_r == MMCC_ST_DELIV && win_r == 3'h1 && !abort_evt) begin
        bus_value <= result_r;
        bus_valid <= 1'b1;
      end
    end
  end

  // Decimal point goes dark for a while after each processed reading.
  always_ff @(posedge core_clk) begin
    if (clear) begin
      dp_cnt_r <= 24'h000000;
    end else if (disp_valid) begin
      dp_cnt_r <= 24'(DP_FLASH_CYC);
    end else if (dp_cnt_r != 24'h000000) begin
      dp_cnt_r <= dp_cnt_r - 24'h000001;
    end
  end

  assign decimal_point = (dp_cnt_r == 24'h000000);

  // Overflow when the range cannot hold the stored baseline.
  assign base_mag = base_val[23] ? 24'(-base_val) : 24'(base_val);
  always_ff @(posedge core_clk) begin
    if (clear) begin
      overflow_message <= 1'b0;
      ovf_d_r          <= 1'b0;
      status_overflow  <= 1'b0;
    end else begin
      overflow_message <= set_r.zero && !arm_r
                          && (range_full < base_mag);
      ovf_d_r          <= overflow_message;
      status_overflow  <= overflow_message & ~ovf_d_r;
    end
  end

  // Converter settings derived from the active rate and filter.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      integ_cycles <= 24'h000000;
      samples_log2 <= 4'h0;
      filter_log2  <= 3'h0;
    end else begin
      if (set_r.rate == 4'h0) begin
        integ_cycles <= 24'(PER_FAST_CYC);
      end else if (set_r.rate >= 4'h6) begin
        integ_cycles <= 24'(PER_SLOW_CYC);
      end else if (line50_r) begin
        integ_cycles <= 24'(PER_LINE50_CYC);
      end else begin
        integ_cycles <= 24'(PER_LINE60_CYC);
      end
      samples_log2 <= rate_samples(set_r.rate);
      filter_log2  <= filt_samples(set_r.filter);
    end
  end

  assign bus_half_digits = `MMCC_BUS_HALF_DIGITS;
  assign zero_lamp       = set_r.zero;

  // Register port: read data stands in the cycle after the strobe.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `MMCC_REG_CTRL:     reg_rdata <= {31'h0, line50_r};
        `MMCC_REG_SETTINGS: reg_rdata <= {19'h0, overflow_message, run_r,
                                          set_r.trig, 1'b0, set_r.filter,
                                          set_r.zero, set_r.rate};
        `MMCC_REG_BASELINE: reg_rdata <= {{8{base_val[23]}}, base_val};
        default:            reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule : mmcc_top
`default_nettype wire

// *** tb/mmcc_conv_model.sv ***
// Converter model: answers each start with the input level after LAT.
// Assumes starts are one-cycle pulses, one conversion at a time.
`default_nettype none
module mmcc_conv_model #(
  parameter int LAT = 4
) (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst,
  // Converter side
  input  wire logic               conv_start,
  input  wire logic signed [23:0] level,
  output logic                    conv_done,
  output logic signed [23:0]      conv_value
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // Outside the done cycle the result toggles, so stale data shows up.
  always_ff @(posedge core_clk) begin
    if (rst)
      cnt <= 0;
    else if (conv_start)
      cnt <= LAT;
    else if (cnt > 0)
      cnt <= cnt - 1;
    conv_done <= !rst && cnt == 1;
    conv_value <= (cnt == 1) ? level : ~conv_value;
  end
endmodule : mmcc_conv_model
`default_nettype wire

// *** tb/mmcc_sva.sv ***
// Checker for the command interpreter, bound to its top module.
// Assumes the converter answers a start no sooner than one cycle later.
`default_nettype none
module mmcc_sva #(
  parameter int unsigned PER_LINE60_CYC = 40
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // Commands
  input wire logic        cmd_valid,
  input wire mmcc_pkg::mmcc_cmd_type cmd,
  // Indicators and readings
  input wire logic        zero_lamp,
  input wire logic        decimal_point,
  input wire logic        overflow_message,
  input wire logic        status_overflow,
  input wire logic        conv_start,
  input wire logic        conversion_done_output,
  input wire logic        disp_valid,
  input wire logic        bus_valid,
  input wire logic [3:0]  bus_half_digits,
  input wire logic [3:0]  samples_log2,
  input wire logic [23:0] integ_cycles
);
  timeunit 1ns;
  timeprecision 1ns;
  import mmcc_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_reset_rate: assert property ($fell(rst) |=>
    integ_cycles == PER_LINE60_CYC && samples_log2 == 4'h1)
    else $error("rate default missing after reset");
  a_reset_zero: assert property ($fell(rst) |-> !zero_lamp)
    else $error("zero lamp lit after reset");
  a_lamp_exec: assert property ($rose(zero_lamp) |->
    $past(cmd_valid && cmd.op == MMCC_OP_EXECUTE))
    else $error("zero lamp lit without execute");
  a_point_dark: assert property (disp_valid |=> !decimal_point)
    else $error("decimal point not dark after reading");
  a_bus_after: assert property (bus_valid |-> $past(disp_valid, 3))
    else $error("bus reading without display three cycles before");
  a_bus_digits: assert property (bus_valid |->
    bus_half_digits == 4'hB)
    else $error("bus reading not five and a half digits");
  a_ovf_status: assert property (status_overflow |-> overflow_message)
    else $error("status overflow without overflow message");
  a_ovf_rise: assert property ($rose(overflow_message) |->
    ##[0:1] status_overflow)
    else $error("overflow not reported in status");
  a_one_conv: assert property (conv_start |=> !conv_start [*5])
    else $error("second start during a conversion");
  a_done_disp: assert property (conversion_done_output |=>
    disp_valid)
    else $error("no display reading after conversion done");

  c_bus: cover property (bus_valid);
  c_ovf: cover property (status_overflow);
  c_zero: cover property ($rose(zero_lamp));
endmodule : mmcc_sva

bind mmcc_top mmcc_sva #(.PER_LINE60_CYC(PER_LINE60_CYC)) i_mmcc_sva (
  .core_clk, .rst, .cmd_valid, .cmd, .zero_lamp, .decimal_point,
  .overflow_message, .status_overflow, .conv_start,
  .conversion_done_output, .disp_valid,
  .bus_valid, .bus_half_digits, .samples_log2, .integ_cycles);
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the command interpreter top.
// Assumes short period parameters and a four-cycle converter model.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import mmcc_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, ext = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, cmd_valid = 1'b0;
  mmcc_cmd_type cmd = '0;
  logic dev_clear = 1'b0, talk_addr = 1'b0, group_trig = 1'b0;
  logic local_lockout = 1'b0, panel_trig = 1'b0, pf_valid = 1'b0;
  logic [1:0] pf = 2'h0;
  logic range_small = 1'b0, zero_lamp, decimal_point, overflow_message;
  logic [2:0] func_sel = 3'h0, filter_log2;
  logic [23:0] range_full = 24'hFFFFFF, integ_cycles;
  logic signed [23:0] level = 24'h0, conv_value, disp_value, bus_value;
  logic conv_start, conv_done, disp_valid, bus_valid, status_overflow;
  logic [3:0] samples_log2, bus_half_digits;
  int n_mismatch = 0, checks = 0, n_start = 0, cyc = 0;

  mmcc_top #(.PER_FAST_CYC(20), .PER_LINE60_CYC(40), .PER_LINE50_CYC(50),
    .PER_SLOW_CYC(100), .DP_FLASH_CYC(10)) i_mmcc_top (
    .core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cmd_valid, .cmd, .dev_clear, .talk_addr, .group_trig, .local_lockout,
    .panel_trig, .panel_filter_valid(pf_valid), .panel_filter(pf),
    .zero_lamp, .decimal_point, .overflow_message,
    .external_trigger_input(ext), .conversion_done_output(), .func_sel,
    .range_full, .range_small, .conv_start, .conv_done, .conv_value,
    .integ_cycles, .samples_log2, .filter_log2, .disp_value, .disp_valid,
    .bus_value, .bus_valid, .bus_half_digits, .status_overflow);
  mmcc_conv_model i_mmcc_conv_model (
    .core_clk, .rst, .conv_start, .level, .conv_done, .conv_value);

  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (conv_start)
      n_start <= n_start + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] exp, got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task automatic send(input mmcc_op_type op, input logic [7:0] a);
    cmd_valid <= 1'b1;
    cmd <= '{op: op, arg: a};
    tick(1);
    cmd_valid <= 1'b0;
    tick(1);
  endtask : send
  task automatic setx(input mmcc_op_type op, input logic [7:0] a);
    send(op, a);
    send(MMCC_OP_EXECUTE, 8'h00);
    tick(1);
    @(negedge core_clk);
    tick(1);
  endtask : setx
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    tick(1);
    reg_rd <= 1'b0;
    @(negedge core_clk) d = reg_rdata;
    tick(1);
  endtask : rd
  // Source 0 talk, 1 group trigger, 2 execute, other the rear pin.
  task automatic fire(input int s);
    case (s)
      0: talk_addr <= 1'b1;
      1: group_trig <= 1'b1;
      2: cmd_valid <= 1'b1;
      default: ext <= 1'b1;
    endcase
    cmd <= '{op: MMCC_OP_EXECUTE, arg: 8'h00};
    tick(1);
    {talk_addr, group_trig, cmd_valid} <= 3'b000;
    tick(2);
    ext <= 1'b0;
    tick(1);
  endtask : fire
  task automatic grab(output logic [23:0] d, b, output logic bv);
    int i;
    b = 'x;
    bv = 1'b0;
    for (i = 0; i < 40 && disp_valid !== 1'b1; i++)
      @(negedge core_clk);
    d = disp_value;
    for (i = 0; i < 6; i++) begin
      @(negedge core_clk);
      if (bus_valid === 1'b1) begin
        bv = 1'b1;
        b = bus_value;
      end
    end
    tick(1);
  endtask : grab
  task automatic meas(input int v, exp);
    logic [23:0] d, b;
    logic bv;
    level <= 24'(v);
    fire(0);
    grab(d, b, bv);
    chk("disp", 24'(exp), d);
    chk("bus", 24'(exp), b);
  endtask : meas

  task automatic t_reset();
    logic [31:0] s;
    rd(8'h04, s);
    chk("settings", 32'h642, s);
    chk("digits", 4'hB, bus_half_digits);
    rd(8'h0C, s);
    chk("unmapped", 32'h0, s);
  endtask : t_reset
  task automatic t_rate();
    int c, l;
    for (l = 0; l < 2; l++) begin
      reg_wr <= 1'b1;
      reg_wdata <= 32'(l);
      reg_addr <= 8'h00;
      tick(1);
      reg_wr <= 1'b0;
      for (c = 0; c < 10; c++) begin
        setx(MMCC_OP_RATE, 8'(c));
        chk("period", c == 0 ? 20 : c > 5 ? 100 : l ? 50 : 40,
          integ_cycles);
        chk("samples", c == 0 ? 0 : c > 5 ? c - 6 : c - 1,
          samples_log2);
      end
    end
    send(MMCC_OP_RATE, 8'h00);
    tick(3);
    chk("pending", 100, integ_cycles);
    setx(MMCC_OP_RATE, 8'h0A);
    chk("applied", 20, integ_cycles);
    setx(MMCC_OP_RATE, 8'h0A);
    chk("range", 20, integ_cycles);
  endtask : t_rate
  task automatic t_filter();
    int a;
    logic [2:0] e [4] = '{3'h0, 3'h6, 3'h5, 3'h3};
    for (a = 0; a < 5; a++) begin
      setx(MMCC_OP_FILTER, 8'(a));
      chk("filter", e[a < 4 ? a : 3], filter_log2);
    end
    setx(MMCC_OP_FILTER, 8'h01);
    pf_valid <= 1'b1;
    tick(1);
    pf_valid <= 1'b0;
    tick(3);
    chk("panel", 3'h6, filter_log2);
  endtask : t_filter
  task automatic t_zero();
    setx(MMCC_OP_TRIGGER, 8'h01);
    setx(MMCC_OP_ZERO, 8'h01);
    chk("lamp_on", 1'b1, zero_lamp);
    chk("point", 1'b1, decimal_point);
    meas(1000, 0);
    meas(1300, 300);
    func_sel <= 3'h1;
    setx(MMCC_OP_ZERO, 8'h01);
    meas(500, 0);
    func_sel <= 3'h0;
    meas(1100, 100);
    setx(MMCC_OP_ZERO, 8'h01);
    meas(700, 0);
    range_full <= 24'd50;
    tick(3);
    chk("ovf", 1'b1, overflow_message);
    range_full <= 24'hFFFFFF;
    tick(12);
    chk("relit", 1'b1, decimal_point);
    setx(MMCC_OP_ZERO, 8'h00);
    chk("lamp_off", 1'b0, zero_lamp);
    meas(900, 900);
  endtask : t_zero
  task automatic t_trig();
    int m, n;
    for (m = 0; m < 8; m++) begin
      setx(MMCC_OP_TRIGGER, 8'(m));
      tick(20);
      n = n_start;
      fire(m / 2);
      tick(40);
      chk("starts", 1'b1, m % 2 ? n_start - n == 1
        : n_start - n > 2);
    end
  endtask : t_trig
  task automatic t_lock();
    int n;
    local_lockout <= 1'b1;
    n = n_start;
    panel_trig <= 1'b1;
    tick(1);
    panel_trig <= 1'b0;
    tick(20);
    chk("panel_lock", 0, n_start - n);
    fire(3);
    tick(20);
    chk("ext_lock", 1, n_start - n);
    local_lockout <= 1'b0;
  endtask : t_lock
  task automatic t_abort();
    int i;
    logic [23:0] d, b;
    logic bv;
    level <= 24'd77;
    fire(3);
    for (i = 0; i < 30 && conv_done !== 1'b1; i++)
      @(negedge core_clk);
    @(posedge core_clk) ext <= 1'b1;
    grab(d, b, bv);
    ext <= 1'b0;
    chk("abort_disp", 24'd77, d);
    chk("abort_bus", 1'b0, bv);
  endtask : t_abort
  task automatic t_clear();
    logic [31:0] s;
    setx(MMCC_OP_RATE, 8'h07);
    send(MMCC_OP_RATE, 8'h03);
    range_small <= 1'b1;
    dev_clear <= 1'b1;
    tick(1);
    dev_clear <= 1'b0;
    send(MMCC_OP_EXECUTE, 8'h00);
    rd(8'h04, s);
    chk("clear", 32'h662, s);
  endtask : t_clear

  initial begin
    tick(12);
    rst <= 1'b0;
    tick(2);
    t_reset();
    t_rate();
    t_filter();
    t_zero();
    t_trig();
    t_lock();
    t_abort();
    t_clear();
    complete_run();
  end
endmodule : tb
`default_nettype wire
